//--- bus_master_model.sv
// Bus master side of one port's shared data wires.
`default_nettype none
module bus_master_model (
   input  wire logic        clock,
   input  wire logic        drive_en,
   input  wire logic [17:0] drive_val,
   input  wire logic [17:0] data_out,
   input  wire logic [17:0] data_oe,
   output var  logic [17:0] pin_level
);
   logic [17:0] last_q = 18'h00000;
   // Floating bits show the inverse of their last level, so a stale value
   // never passes; both sides driving shows as unknown.
   always_comb begin
      for (int i = 0; i < 18; i++) begin
         pin_level[i] = data_oe[i] ? (drive_en ? 1'bx : data_out[i])
                                   : (drive_en ? drive_val[i] : ~last_q[i]);
      end
   end
   always_ff @(posedge clock) begin
      last_q <= pin_level;
   end
endmodule
`default_nettype wire

//--- dpsram_pkg.sv
// Shared constants for the dual-port synchronous memory port logic.
`default_nettype none

package dpsram_pkg;

   // Array geometry: two ports, 64K words, two byte lanes of nine bits.
   localparam int N_PORTS   = 2;
   localparam int ADDR_W    = 16;
   localparam int LANE_W    = 9;
   localparam int N_LANES   = 2;
   localparam int DATA_W    = LANE_W * N_LANES;

   // Lane positions inside a data word.
   localparam int LOWER_LANE = 0;
   localparam int UPPER_LANE = 1;

   // Address forced by the counter clear input.
   localparam logic [ADDR_W-1:0] COUNTER_CLEAR_ADDR = 16'h0000;

   // Reset values of the address counter and the access pipeline.
   localparam logic [ADDR_W-1:0] COUNTER_RESET  = 16'h0000;
   localparam logic [DATA_W-1:0] DATA_RESET     = 18'h00000;
   localparam logic [N_LANES-1:0] LANES_RESET   = 2'h0;

   // Reset levels of the filtered asynchronous pins.
   localparam logic OUTPUT_ENABLE_N_RESET = 1'h1;
   localparam logic LATENCY_SELECT_RESET  = 1'h0;

   // Output latency modes as seen on the latency-select pin.
   typedef enum logic [0:0] {
      LATENCY_FLOW = 1'b0,
      LATENCY_PIPE = 1'b1
   } latency_t;

   // Port-to-port timing that the far side must respect.
   localparam int CLOCK_PERIOD_PS    = 5000;
   localparam int WRITE_TO_READ_NS   = 28;
   localparam int CLOCK_SKEW_NS      = 10;
   localparam int WRITE_TO_READ_CYC  =
      (WRITE_TO_READ_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
   localparam int CLOCK_SKEW_CYC     =
      (CLOCK_SKEW_NS * 1000) / CLOCK_PERIOD_PS;

endpackage

`default_nettype wire

//--- dpsram_sva.sv
// Checker on the port pins of the two-port memory.
`default_nettype none
module dpsram_sva #(
   parameter int ADDR_W = 16,
   parameter int LANE_W = 9,
   parameter int DATA_W = 18
) (
   input wire logic                   clock,
   input wire logic                   rstn,
   input wire logic [1:0]             chip_select_active_low_n,
   input wire logic [1:0]             upper_lane_select_n,
   input wire logic [1:0]             read_write_n,
   input wire logic [1:0]             address_load_strobe_n,
   input wire logic [1:0]             counter_advance_n,
   input wire logic [1:0]             counter_clear_n,
   input wire logic [1:0]             output_enable_n,
   input wire logic [1:0][ADDR_W-1:0] address,
   input wire logic [1:0][DATA_W-1:0] data_oe,
   input wire logic [1:0][ADDR_W-1:0] internal_address
);
   default clocking dc @(posedge clock);
   endclocking
   default disable iff (!rstn);
   // Address source priority: clear, then load, then advance, else hold.
   clear_zero_a: assert property (
      !counter_clear_n[0] |=> internal_address[0] == '0)
      else $error("clear did not force address zero");
   load_addr_a: assert property (
      counter_clear_n[0] && !address_load_strobe_n[0]
      |=> internal_address[0] == $past(address[0]))
      else $error("external address not loaded");
   advance_one_a: assert property (
      counter_clear_n[0] && address_load_strobe_n[0] && !counter_advance_n[0]
      |=> internal_address[0] == $past(internal_address[0]) + 16'h0001)
      else $error("counter did not advance by one");
   addr_hold_a: assert property (
      counter_clear_n[0] && address_load_strobe_n[0] && counter_advance_n[0]
      |=> $stable(internal_address[0]))
      else $error("address moved while held");
   // Three idle cycles outlast both the single and double select stages.
   deselect_float_a: assert property (
      chip_select_active_low_n[1] [*3] |=> data_oe[1] == '0)
      else $error("deselected port still drives");
   upper_float_a: assert property (
      upper_lane_select_n[0] [*3] |=> data_oe[0][DATA_W-1:LANE_W] == '0)
      else $error("unselected upper lane drives");
   // The enable filter lags a few cycles, so six cycles are allowed.
   enable_off_a: assert property (
      output_enable_n[1] [*6] |=> data_oe[1] == '0)
      else $error("data driven with enable off");
   write_quiet_a: assert property (
      !read_write_n[1] [*3] |=> data_oe[1] == '0)
      else $error("data driven during writes");
endmodule
bind dual_port_sync_sram_port dpsram_sva #(
   .ADDR_W(ADDR_W),
   .LANE_W(LANE_W),
   .DATA_W(DATA_W)
) u_dpsram_sva (
   .clock(clock),
   .rstn(rstn),
   .chip_select_active_low_n(chip_select_active_low_n),
   .upper_lane_select_n(upper_lane_select_n),
   .read_write_n(read_write_n),
   .address_load_strobe_n(address_load_strobe_n),
   .counter_advance_n(counter_advance_n),
   .counter_clear_n(counter_clear_n),
   .output_enable_n(output_enable_n),
   .address(address),
   .data_oe(data_oe),
   .internal_address(internal_address)
);
`default_nettype wire

//--- dual_port_sync_sram_port.sv
// Two-port synchronous memory: port access pipelines and shared array.
`default_nettype none

// What this block does
// - Each port picks pipelined (pin high) or flow-through (low) latency alone.
// - Port inputs sample on the rising clock; enable and latency pins are async.
// - Deselect or a high lane select tri-states data after the second edge (the third in pipelined mode).
// - In pipelined reads, a lane deselected at registration floats its later beat.
// - Address load strobe low captures the external address every edge that clear is high.
// - Output drive state of a cycle follows controls registered the cycle before (two cycles before in pipelined mode).
// - Clear, load strobe and advance all high hold the address and read data.
// - Both ports behave identically; either may write while the other reads.
// - Chip selects are double-registered in pipelined mode, single in flow-through.
// - Pipelined read data arrives one clock later than flow-through data.
// - Counter advances when advance is low and load strobe high; clear low forces address zero first.
// - A selected write updates only lanes whose active-low select is low.
module dual_port_sync_sram_port #(
   parameter int N_PORTS = dpsram_pkg::N_PORTS,
   parameter int ADDR_W  = dpsram_pkg::ADDR_W,
   parameter int LANE_W  = dpsram_pkg::LANE_W,
   parameter int N_LANES = dpsram_pkg::N_LANES,
   parameter int DATA_W  = dpsram_pkg::DATA_W
) (
   input  wire logic                            clock,
   input  wire logic                            rstn,
   input  wire logic [N_PORTS-1:0]              chip_select_active_low_n,
   input  wire logic [N_PORTS-1:0]              chip_select_active_high,
   input  wire logic [N_PORTS-1:0]              upper_lane_select_n,
   input  wire logic [N_PORTS-1:0]              lower_lane_select_n,
   input  wire logic [N_PORTS-1:0]              read_write_n,
   input  wire logic [N_PORTS-1:0]              address_load_strobe_n,
   input  wire logic [N_PORTS-1:0]              counter_advance_n,
   input  wire logic [N_PORTS-1:0]              counter_clear_n,
   input  wire logic [N_PORTS-1:0]              output_enable_n,
   input  wire logic [N_PORTS-1:0]              output_latency_select,
   input  wire logic [N_PORTS-1:0][ADDR_W-1:0]  address,
   input  wire logic [N_PORTS-1:0][DATA_W-1:0]  data_in,
   output var  logic [N_PORTS-1:0][DATA_W-1:0]  data_out,
   output var  logic [N_PORTS-1:0][DATA_W-1:0]  data_oe,
   output var  logic [N_PORTS-1:0][ADDR_W-1:0]  internal_address
);

   localparam int DEPTH = 1 << ADDR_W;

   // The shared array; each word holds both byte lanes.
   logic [DATA_W-1:0] mem [DEPTH];

   // Filtered asynchronous pins.
   logic [N_PORTS-1:0] oe_n_level;
   logic [N_PORTS-1:0] pipe_level;

   // Registered access of each port (first stage).
   logic [N_PORTS-1:0][ADDR_W-1:0]  cnt_q,   cnt_d;
   logic [N_PORTS-1:0]              rd_q,    rd_d;
   logic [N_PORTS-1:0]              wr_q,    wr_d;
   logic [N_PORTS-1:0][N_LANES-1:0] lanes_q, lanes_d;
   logic [N_PORTS-1:0][DATA_W-1:0]  wdata_q, wdata_d;

   // Middle stage used only by the pipelined latency.
   logic [N_PORTS-1:0]              mid_rd_q,    mid_rd_d;
   logic [N_PORTS-1:0][N_LANES-1:0] mid_lanes_q, mid_lanes_d;
   logic [N_PORTS-1:0][DATA_W-1:0]  mid_data_q,  mid_data_d;

   // Output stage: data word and per-lane drive state.
   logic [N_PORTS-1:0][N_LANES-1:0] drive_q, drive_d;
   logic [N_PORTS-1:0][DATA_W-1:0]  out_q,   out_d;

   // Output enable and latency select are asynchronous pins, so they are
   // filtered first; this adds a few clocks before an enable change shows.
   pin_filter #(
      .WIDTH       (N_PORTS),
      .RESET_LEVEL (dpsram_pkg::OUTPUT_ENABLE_N_RESET)
   ) u_oe_filter (
      .clock     (clock),
      .rstn      (rstn),
      .pin_in    (output_enable_n),
      .level_out (oe_n_level)
   );

   pin_filter #(
      .WIDTH       (N_PORTS),
      .RESET_LEVEL (dpsram_pkg::LATENCY_SELECT_RESET)
   ) u_latency_filter (
      .clock     (clock),
      .rstn      (rstn),
      .pin_in    (output_latency_select),
      .level_out (pipe_level)
   );

   // The same pipeline is built for each port, so both ports behave alike.
   for (genvar p = 0; p < N_PORTS; p++) begin : g_port

      logic selected;
      logic [N_LANES-1:0] lane_on;

      // Both chip selects must agree, then the lane selects pick lanes.
      assign selected = !chip_select_active_low_n[p]
                        && chip_select_active_high[p];
      assign lane_on[dpsram_pkg::UPPER_LANE] = !upper_lane_select_n[p];
      assign lane_on[dpsram_pkg::LOWER_LANE] = !lower_lane_select_n[p];

      // Input registration, address counter and read pipeline of the port.
      always_comb begin
         cnt_d[p] = cnt_q[p];
         if (!counter_clear_n[p]) begin
            cnt_d[p] = dpsram_pkg::COUNTER_CLEAR_ADDR;
         end else if (!address_load_strobe_n[p]) begin
            cnt_d[p] = address[p];
         end else if (!counter_advance_n[p]) begin
            cnt_d[p] = cnt_q[p] + ADDR_W'(1);
         end else begin
            cnt_d[p] = cnt_q[p];
         end

         // Every synchronous input is captured on the rising edge.
         rd_d[p]    = selected && read_write_n[p] && (|lane_on);
         wr_d[p]    = selected && !read_write_n[p] && (|lane_on);
         lanes_d[p] = selected ? lane_on : dpsram_pkg::LANES_RESET;
         wdata_d[p] = data_in[p];

         // Middle stage delays the chip and lane selects one more clock.
         mid_rd_d[p]    = rd_q[p];
         mid_lanes_d[p] = lanes_q[p];
         mid_data_d[p]  = mem[cnt_q[p]];

         // Output state comes from the controls registered a cycle before, or two cycles before in pipelined mode.
         if (pipe_level[p] == dpsram_pkg::LATENCY_PIPE) begin
            out_d[p]   = mid_data_q[p];
            drive_d[p] = mid_rd_q[p] ? mid_lanes_q[p]
                                     : dpsram_pkg::LANES_RESET;
         end else begin
            out_d[p]   = mem[cnt_q[p]];
            drive_d[p] = rd_q[p] ? lanes_q[p]
                                 : dpsram_pkg::LANES_RESET;
         end
      end

      // Registers of the port; the array itself has no reset.
      always_ff @(posedge clock or negedge rstn) begin
         if (!rstn) begin
            cnt_q[p]       <= dpsram_pkg::COUNTER_RESET;
            rd_q[p]        <= 1'b0;
            wr_q[p]        <= 1'b0;
            lanes_q[p]     <= dpsram_pkg::LANES_RESET;
            wdata_q[p]     <= dpsram_pkg::DATA_RESET;
            mid_rd_q[p]    <= 1'b0;
            mid_lanes_q[p] <= dpsram_pkg::LANES_RESET;
            mid_data_q[p]  <= dpsram_pkg::DATA_RESET;
            drive_q[p]     <= dpsram_pkg::LANES_RESET;
            out_q[p]       <= dpsram_pkg::DATA_RESET;
         end else begin
            cnt_q[p]       <= cnt_d[p];
            rd_q[p]        <= rd_d[p];
            wr_q[p]        <= wr_d[p];
            lanes_q[p]     <= lanes_d[p];
            wdata_q[p]     <= wdata_d[p];
            mid_rd_q[p]    <= mid_rd_d[p];
            mid_lanes_q[p] <= mid_lanes_d[p];
            mid_data_q[p]  <= mid_data_d[p];
            drive_q[p]     <= drive_d[p];
            out_q[p]       <= out_d[p];
         end
      end

      // Pins drive only while the enable is low and a selected read stands.
      for (genvar l = 0; l < N_LANES; l++) begin : g_lane
         assign data_oe[p][l*LANE_W +: LANE_W] =
            {LANE_W{drive_q[p][l] && !oe_n_level[p]}};
      end

      assign data_out[p]         = out_q[p];
      assign internal_address[p] = cnt_q[p];
   end

   // Registered writes land one clock after capture. When both ports write
   // the same lane of the same word, the higher port wins; callers should
   // avoid that case since the result is not otherwise defined.
   always_ff @(posedge clock) begin
      for (int p = 0; p < N_PORTS; p++) begin
         for (int l = 0; l < N_LANES; l++) begin
            if (wr_q[p] && lanes_q[p][l]) begin
               mem[cnt_q[p]][l*LANE_W +: LANE_W] <=
                  wdata_q[p][l*LANE_W +: LANE_W];
            end
         end
      end
   end

endmodule

`default_nettype wire

//--- pin_filter.sv
// Three-flop synchroniser with agreement filter for asynchronous pins.
`default_nettype none

module pin_filter #(
   parameter int         WIDTH       = 1,
   parameter logic [0:0] RESET_LEVEL = 1'b0
) (
   input  wire logic             clock,
   input  wire logic             rstn,
   input  wire logic [WIDTH-1:0] pin_in,
   output var  logic [WIDTH-1:0] level_out
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] hist_q;
   logic [WIDTH-1:0] level_q;
   logic [WIDTH-1:0] level_d;

   // A change is taken only once the second and third flop agree.
   always_comb begin
      level_d = level_q;
      for (int i = 0; i < WIDTH; i++) begin
         if (sync_q[i] == hist_q[i]) begin
            level_d[i] = hist_q[i];
         end
      end
   end

   // The first flop feeds only the second, keeping metastability contained.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         meta_q  <= {WIDTH{RESET_LEVEL}};
         sync_q  <= {WIDTH{RESET_LEVEL}};
         hist_q  <= {WIDTH{RESET_LEVEL}};
         level_q <= {WIDTH{RESET_LEVEL}};
      end else begin
         meta_q  <= pin_in;
         sync_q  <= meta_q;
         hist_q  <= sync_q;
         level_q <= level_d;
      end
   end

   assign level_out = level_q;

endmodule

`default_nettype wire

//--- tb.sv
// Self-checking bench for the two-port memory port logic.
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic             clock = 1'b0;
   logic             rstn = 1'b0;
   logic [1:0]       cs_n = 2'h3, cs = 2'h3, ub_n = 2'h3, lb_n = 2'h3;
   logic [1:0]       rw_n = 2'h1, ads_n = 2'h3, cnt_n = 2'h3, clr_n = 2'h3;
   logic [1:0]       oe_n = 2'h3, lat = 2'h2, drv_en = 2'h0;
   logic [1:0][15:0] addr = '0, iaddr;
   logic [1:0][17:0] drv_val = '0, pin, dout, doe;
   int               err_count = 0, tests_run = 0, cycles = 0;
   dual_port_sync_sram_port u_dual_port_sync_sram_port (
      .clock(clock), .rstn(rstn), .chip_select_active_low_n(cs_n),
      .chip_select_active_high(cs), .upper_lane_select_n(ub_n),
      .lower_lane_select_n(lb_n), .read_write_n(rw_n),
      .address_load_strobe_n(ads_n), .counter_advance_n(cnt_n),
      .counter_clear_n(clr_n), .output_enable_n(oe_n),
      .output_latency_select(lat), .address(addr), .data_in(pin),
      .data_out(dout), .data_oe(doe), .internal_address(iaddr));
   bus_master_model m0 (.clock(clock), .drive_en(drv_en[0]),
      .drive_val(drv_val[0]), .data_out(dout[0]), .data_oe(doe[0]),
      .pin_level(pin[0]));
   bus_master_model m1 (.clock(clock), .drive_en(drv_en[1]),
      .drive_val(drv_val[1]), .data_out(dout[1]), .data_oe(doe[1]),
      .pin_level(pin[1]));
   always #2.5 clock = ~clock;
   task automatic check(input string what, input logic [17:0] seen,
                        input logic [17:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   task automatic cyc(input int n = 1);
      repeat (n) @(posedge clock);
      #1;
   endtask
   // Selected access on port p; lanes_n is {upper, lower}, active low.
   task automatic access(input int p, input logic w, input logic [1:0] lanes_n,
                         input logic [15:0] a, input logic [17:0] d);
      cs_n[p] = 1'b0;
      {ub_n[p], lb_n[p]} = lanes_n;
      rw_n[p] = ~w;
      ads_n[p] = 1'b0;
      addr[p] = a;
      drv_en[p] = w;
      drv_val[p] = d;
      cyc();
   endtask
   task automatic idle(input int p);
      cs_n[p] = 1'b1;
      {ub_n[p], lb_n[p]} = 2'h3;
      ads_n[p] = 1'b1;
      drv_en[p] = 1'b0;
   endtask
   // Writes precede reads, so no idle cycle sits between them.
   task automatic t_flow();
      oe_n[0] = 1'b0;
      cyc(6);
      access(0, 1, 2'h0, 16'h0005, 18'h2a5a5);
      access(0, 1, 2'h1, 16'h0005, 18'h3ffff);
      access(0, 0, 2'h0, 16'h0005, 18'h00000);
      check("addr", {2'h0, iaddr[0]}, 18'h00005);
      access(0, 0, 2'h1, 16'h0005, 18'h00000);
      check("rd", pin[0], {9'h1ff, 9'h1a5});
      check("oe", doe[0], 18'h3ffff);
      idle(0);
      cyc();
      check("oe_up", doe[0], 18'h3fe00);
      cyc();
      check("oe_off", doe[0], 18'h00000);
   endtask
   // The reader starts long after the other port's write.
   task automatic t_pipe();
      oe_n[1] = 1'b0;
      cyc(6);
      access(1, 0, 2'h0, 16'h0005, 18'h00000);
      idle(1);
      cyc();
      check("early", doe[1], 18'h00000);
      cyc();
      check("pipe_rd", pin[1], {9'h1ff, 9'h1a5});
      cyc();
      check("pipe_off", doe[1], 18'h00000);
   endtask
   task automatic t_counter();
      clr_n[0] = 1'b0;
      ads_n[0] = 1'b0;
      addr[0] = 16'h1234;
      cyc();
      check("clear", {2'h0, iaddr[0]}, 18'h00000);
      clr_n[0] = 1'b1;
      addr[0] = 16'hfffe;
      cyc();
      ads_n[0] = 1'b1;
      cnt_n[0] = 1'b0;
      for (int i = 1; i <= 3; i++) begin
         cyc();
         check("count", {2'h0, iaddr[0]}, {2'h0, 16'hfffe + 16'(i)});
      end
      cnt_n[0] = 1'b1;
      addr[0] = 16'h4321;
      cyc(2);
      check("hold", {2'h0, iaddr[0]}, 18'h00001);
   endtask
   // Port 1 writes and port 0 reads the word back once the port-to-port
   // delay has passed; then lane and active-high select gating.
   task automatic t_swap();
      access(1, 1, 2'h0, 16'h0009, 18'h1c3c3);
      idle(1);
      cyc(dpsram_pkg::WRITE_TO_READ_CYC);
      access(0, 0, 2'h0, 16'h0009, 18'h00000);
      idle(0);
      cyc();
      check("swap_rd", pin[0], {9'h0e1, 9'h1c3});
      access(1, 0, 2'h2, 16'h0009, 18'h00000);
      idle(1);
      cyc(2);
      check("pipe_lane", doe[1], 18'h001ff);
      check("pipe_lo", {9'h000, pin[1][8:0]}, 18'h001c3);
      cs[0] = 1'b0;
      access(0, 0, 2'h0, 16'h0009, 18'h00000);
      cyc();
      check("cs_off", doe[0], 18'h00000);
      cs[0] = 1'b1;
      idle(0);
      cyc();
   endtask
   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("bench passed");
      end
      else begin
         $display("bench failed");
      end
      $finish;
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 500) begin
         err_count++;
         give_verdict();
      end
   end
   initial begin
      cyc(2);
      rstn = 1'b1;
      check("rst_oe", doe[0], 18'h00000);
      check("rst_addr", {2'h0, iaddr[0]}, 18'h00000);
      t_flow();
      t_pipe();
      t_counter();
      t_swap();
      give_verdict();
   end
endmodule
`default_nettype wire
